// [common/isl_defs.svh]
// Purpose: constants of the interrupt source logic
// Assumes: included by its bare name
// Notes:   edge codes, vector map, group membership
`ifndef ISL_DEFS_SVH
`define ISL_DEFS_SVH

// ------------------------------------------------------------
// edge select codes, two bits per external pin
// ------------------------------------------------------------
`define ISL_EDGE_OFF  2'h0
`define ISL_EDGE_RISE 2'h1
`define ISL_EDGE_FALL 2'h2
`define ISL_EDGE_BOTH 2'h3

// ------------------------------------------------------------
// vectors, index 0 has the highest priority
// ------------------------------------------------------------
`define ISL_NVEC      13
`define ISL_V_EXT0    4'h0
`define ISL_V_CMP0    4'h4
`define ISL_V_ADC     4'h6
`define ISL_V_GRP0    4'h7
`define ISL_VEC_BASE  12'h004
`define ISL_VEC_STEP  12'h004

// ------------------------------------------------------------
// grouped source flags and their group membership
// ------------------------------------------------------------
`define ISL_NSRC      20
`define ISL_NGRP      6
`define ISL_GRP0_MASK 20'h0000F
`define ISL_GRP1_MASK 20'h000F0
`define ISL_GRP2_MASK 20'h00300
`define ISL_GRP3_MASK 20'h1C000
`define ISL_GRP4_MASK 20'h03C00
`define ISL_GRP5_MASK 20'hE0000
`define ISL_SRC_LVD   14
`define ISL_SRC_EE    15
`define ISL_SRC_SIM   16
`define ISL_SRC_UART0 17

`endif

// [common/isl_pkg.sv]
// Purpose: types of the interrupt source logic
// Assumes: isl_defs.svh holds the numbers
// Notes:   types only
package isl_pkg;
  typedef logic [1:0]  isl_edge_t;
  typedef logic [3:0]  isl_vidx_t;
  typedef logic [11:0] isl_vaddr_t;
  typedef logic [19:0] isl_src_t;
  typedef logic [12:0] isl_req_t;
endpackage

// [hw/isl_irq.sv]
// Purpose: request flags, gating, priority and vector entry
// Assumes: core samples TAKE/VEC_ADDR and pushes its own PC
// Notes:   pins and comparator outputs are synchronised here
`timescale 1ns/1ps
`include "isl_defs.svh"

module isl_irq (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic [3:0]        EXT_PIN,
  input  wire logic [3:0]        EXT_EN,
  input  wire logic [3:0]        EXT_PIN_SEL,
  input  wire logic [3:0]        EXT_DIR_IN,
  input  wire logic [3:0]        EXT_PULL_SEL,
  input  wire logic [7:0]        EXT_EDGE,
  input  wire logic [3:0]        EXT_CLR,
  input  wire logic [1:0]        CMP_OUT,
  input  wire logic [1:0]        CMP_EN,
  input  wire logic [1:0]        CMP_CLR,
  input  wire logic              ADC_DONE,
  input  wire logic              ADC_EN,
  input  wire logic              ADC_CLR,
  input  wire logic [13:0]       TM_EV,
  input  wire logic              LVD_EV,
  input  wire logic              EE_EV,
  input  wire logic [2:0]        SIM_EV,
  input  wire logic [17:0]       UART_EV,
  input  wire isl_pkg::isl_src_t SRC_EN,
  input  wire isl_pkg::isl_src_t SRC_CLR,
  input  wire logic [5:0]        GRP_EN,
  input  wire logic [5:0]        GRP_CLR,
  input  wire logic              GIE_SET,
  input  wire logic              GIE_CLR,
  input  wire logic              RETURN_FROM_IRQ_INSTR,
  input  wire logic              STACK_FULL,
  input  wire logic              CORE_READY,
  output logic                   GLOBAL_EN,
  output logic                   TAKE,
  output isl_pkg::isl_vaddr_t    VEC_ADDR,
  output logic [3:0]             EXT_FLAG,
  output logic [1:0]             CMP_FLAG,
  output logic                   ADC_FLAG,
  output logic [5:0]             GRP_FLAG,
  output isl_pkg::isl_src_t      SRC_FLAG,
  output logic [3:0]             PULL_EN,
  output logic                   WAKE
);
  import isl_pkg::*;

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic edge_hit(isl_edge_t sel, logic now,
                                    logic old);
    unique case (sel)
      `ISL_EDGE_OFF:  edge_hit = 1'b0;
      `ISL_EDGE_RISE: edge_hit = now & ~old;
      `ISL_EDGE_FALL: edge_hit = ~now & old;
      `ISL_EDGE_BOTH: edge_hit = now ^ old;
    endcase
  endfunction

  function automatic isl_src_t grp_mask(int g);
    case (g)
      0:       grp_mask = `ISL_GRP0_MASK;
      1:       grp_mask = `ISL_GRP1_MASK;
      2:       grp_mask = `ISL_GRP2_MASK;
      3:       grp_mask = `ISL_GRP3_MASK;
      4:       grp_mask = `ISL_GRP4_MASK;
      default: grp_mask = `ISL_GRP5_MASK;
    endcase
  endfunction

  // lowest index wins, so the order of the vectors is the priority
  function automatic isl_vidx_t pick(isl_req_t r);
    pick = 4'h0;
    for (int i = `ISL_NVEC - 1; i >= 0; i--) begin
      if (r[i]) begin
        pick = i[3:0];
      end
    end
  endfunction

  function automatic isl_vaddr_t vaddr(isl_vidx_t v);
    vaddr = `ISL_VEC_BASE + `ISL_VEC_STEP * {8'h00, v};
  endfunction

  // ------------------------------------------------------------
  // synchronisers: stage 1 feeds stage 2 only
  // ------------------------------------------------------------
  logic [3:0] ext_s1;
  logic [3:0] ext_s2;
  logic [3:0] ext_s3;
  logic [1:0] cmp_s1;
  logic [1:0] cmp_s2;
  logic [1:0] cmp_s3;

  // no reset: the chain follows the pins through reset, so a pin that
  // idles high gives no false edge at release; reset must last three
  // cycles to fill it
  always_ff @(posedge CLK) begin
    ext_s1 <= EXT_PIN;
    ext_s2 <= ext_s1;
    ext_s3 <= ext_s2;
    cmp_s1 <= CMP_OUT;
    cmp_s2 <= cmp_s1;
    cmp_s3 <= cmp_s2;
  end

  // ------------------------------------------------------------
  // set events
  // ------------------------------------------------------------
  logic [3:0] ext_route;
  logic [3:0] ext_set;
  logic [1:0] cmp_set;
  logic [2:0] uart_set;
  isl_src_t   src_set;
  isl_src_t   src_rise;
  logic [5:0] grp_set;
  logic [5:0] grp_live;

  assign ext_route = EXT_EN & EXT_PIN_SEL & EXT_DIR_IN;
  assign cmp_set   = cmp_s2 ^ cmp_s3;

  for (genvar i = 0; i < 4; i++) begin : g_ext
    assign ext_set[i] = ext_route[i]
      & edge_hit(EXT_EDGE[2*i +: 2], ext_s2[i], ext_s3[i]);
  end

  // any of six conditions raises the flag; status stays in the UART
  for (genvar u = 0; u < 3; u++) begin : g_uart
    assign uart_set[u] = |UART_EV[6*u +: 6];
  end

  // timers fill bits 13..0 as period/compare pairs
  assign src_set = {uart_set, |SIM_EV, EE_EV, LVD_EV,
                    TM_EV};
  assign src_rise = src_set & ~SRC_FLAG;

  for (genvar g = 0; g < `ISL_NGRP; g++) begin : g_grp
    assign grp_set[g]  = |(src_rise & grp_mask(g));
    assign grp_live[g] = |(SRC_FLAG & SRC_EN & grp_mask(g));
  end

  // ------------------------------------------------------------
  // gating and priority
  // ------------------------------------------------------------
  isl_req_t   req;
  logic       take_ok;
  isl_vidx_t  win;
  isl_vaddr_t win_addr;
  isl_req_t   win_1h;

  assign req = {GRP_FLAG & GRP_EN & grp_live,
                ADC_FLAG & ADC_EN,
                CMP_FLAG & CMP_EN,
                EXT_FLAG & EXT_EN};
  // core must be at an instruction boundary to enter a vector
  assign take_ok  = GLOBAL_EN & ~STACK_FULL & CORE_READY
                    & (|req);
  assign win      = pick(req);
  assign win_addr = vaddr(win);
  assign win_1h   = take_ok ? isl_req_t'(1) << win : '0;

  // ------------------------------------------------------------
  // next state; a flag set always wins over any clear
  // ------------------------------------------------------------
  logic [3:0] next_ext;
  logic [1:0] next_cmp;
  logic       next_adc;
  logic [5:0] next_grp;
  isl_src_t   next_src;
  logic       next_ge;
  logic       next_wake;

  assign next_ext = (EXT_FLAG & ~(EXT_CLR | win_1h[3:0]))
                    | ext_set;
  assign next_cmp = (CMP_FLAG & ~(CMP_CLR | win_1h[5:4]))
                    | cmp_set;
  assign next_adc = (ADC_FLAG & ~(ADC_CLR | win_1h[6]))
                    | ADC_DONE;
  assign next_grp = (GRP_FLAG & ~(GRP_CLR | win_1h[12:7]))
                    | grp_set;
  assign next_src = (SRC_FLAG & ~SRC_CLR) | src_set;

  // entry beats a same-cycle write, so nesting needs a later set
  assign next_ge = take_ok         ? 1'b0 :
                   (RETURN_FROM_IRQ_INSTR | GIE_SET) ? 1'b1 :
                   GIE_CLR          ? 1'b0 : GLOBAL_EN;

  assign next_wake = |({next_ext, next_cmp, next_adc, next_grp,
                        next_src}
                       & ~{EXT_FLAG, CMP_FLAG, ADC_FLAG, GRP_FLAG,
                           SRC_FLAG});

  always_ff @(posedge CLK) begin
    if (RST) begin
      EXT_FLAG  <= 4'h0;
      CMP_FLAG  <= 2'h0;
      ADC_FLAG  <= 1'b0;
      GRP_FLAG  <= 6'h00;
      SRC_FLAG  <= 20'h00000;
      GLOBAL_EN <= 1'b0;
      TAKE      <= 1'b0;
      VEC_ADDR  <= 12'h000;
      PULL_EN   <= 4'h0;
      WAKE      <= 1'b0;
    end else begin
      EXT_FLAG  <= next_ext;
      CMP_FLAG  <= next_cmp;
      ADC_FLAG  <= next_adc;
      GRP_FLAG  <= next_grp;
      SRC_FLAG  <= next_src;
      GLOBAL_EN <= next_ge;
      TAKE      <= take_ok;
      if (take_ok) begin
        VEC_ADDR <= win_addr;
      end
      PULL_EN   <= EXT_PULL_SEL;
      WAKE      <= next_wake;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_enter;
    take_ok ##1 (TAKE && !GLOBAL_EN);
  endsequence

  sequence s_any_rise;
    $rose(ADC_FLAG) || (|(EXT_FLAG & ~$past(EXT_FLAG)));
  endsequence

  a_ext_edge_set: assert property (
    !$past(RST) |-> (EXT_FLAG & $past(ext_set)) == $past(ext_set))
    else $error("pin edge did not set its flag");

  a_ext_route: assert property (
    (EXT_FLAG & ~$past(EXT_FLAG) & ~$past(ext_route)) == 4'h0)
    else $error("unrouted pin set a flag");

  a_take_gate: assert property (
    TAKE |-> $past(GLOBAL_EN) && !$past(STACK_FULL))
    else $error("vector taken while blocked");

  a_take_clr_ge: assert property (take_ok |-> s_enter)
    else $error("global enable kept after entry");

  a_ext_auto_clr: assert property (
    take_ok && win < `ISL_V_CMP0 && !ext_set[win[1:0]]
    |=> !EXT_FLAG[$past(win[1:0])])
    else $error("pin flag not cleared on entry");

  a_pull_hold: assert property (
    !$past(RST) |-> PULL_EN == $past(EXT_PULL_SEL))
    else $error("pull-high selection lost");

  a_cmp_toggle: assert property (
    (|cmp_set) |=> (CMP_FLAG & $past(cmp_set)) == $past(cmp_set))
    else $error("comparator change missed");

  a_adc_set: assert property (ADC_DONE |=> ADC_FLAG)
    else $error("conversion done not flagged");

  a_adc_clr: assert property (
    take_ok && win == `ISL_V_ADC && !ADC_DONE |=> !ADC_FLAG)
    else $error("conversion flag not cleared on entry");

  a_grp_keep_src: assert property (
    take_ok && win >= `ISL_V_GRP0 && SRC_CLR == '0
    |=> (SRC_FLAG & $past(SRC_FLAG)) == $past(SRC_FLAG))
    else $error("group entry cleared a source flag");

  a_wake_rise: assert property (s_any_rise |-> WAKE)
    else $error("flag rise gave no wake");

  a_return_from_irq_instr_ge: assert property (
    RETURN_FROM_IRQ_INSTR && !take_ok |=> GLOBAL_EN)
    else $error("return did not restore enable");

  a_one_vector: assert property (
    take_ok |=> TAKE && VEC_ADDR == $past(win_addr) ##1 !TAKE)
    else $error("vector entry wrong or repeated");

  a_grp_set: assert property (
    (|grp_set) |=> (GRP_FLAG & $past(grp_set)) == $past(grp_set))
    else $error("member rise did not set its group flag");

  a_grp_clr: assert property (
    take_ok && win >= `ISL_V_GRP0 && !grp_set[3'(win - `ISL_V_GRP0)]
    |=> !GRP_FLAG[$past(3'(win - `ISL_V_GRP0))])
    else $error("group flag not cleared on entry");

  a_cmp_clr: assert property (
    take_ok && (win == `ISL_V_CMP0 || win == `ISL_V_CMP0 + 4'h1)
    && !cmp_set[win[0]] |=> !CMP_FLAG[$past(win[0])])
    else $error("comparator flag not cleared on entry");

  a_timer_flags: assert property (
    (|TM_EV) |=> (SRC_FLAG[13:0] & $past(TM_EV)) == $past(TM_EV))
    else $error("timer match not flagged");

  a_lvd_flag: assert property (LVD_EV |=> SRC_FLAG[`ISL_SRC_LVD])
    else $error("low-voltage event not flagged");

  a_ee_flag: assert property (EE_EV |=> SRC_FLAG[`ISL_SRC_EE])
    else $error("erase or write end not flagged");

  a_sim_flag: assert property ((|SIM_EV) |=> SRC_FLAG[`ISL_SRC_SIM])
    else $error("serial event not flagged");

  a_uart_flag: assert property (
    (|UART_EV[5:0]) |=> SRC_FLAG[`ISL_SRC_UART0])
    else $error("uart condition not flagged");

  a_wake_src: assert property (
    (|(SRC_FLAG & ~$past(SRC_FLAG))) |-> WAKE)
    else $error("source flag rise gave no wake");

endmodule

// [testbench/isl_core.sv]
// Purpose: core sequencer model facing the interrupt logic
// Assumes: one vector entry per TAKE pulse
// Notes:   small stack depth so that a full stack is reached fast
`timescale 1ns/1ps
module isl_core #(
  parameter int DEPTH = 1
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       TAKE,
  input  wire logic       RET_IRQ,
  input  wire logic       SLOW,
  output logic            CORE_READY,
  output logic            STACK_FULL,
  output logic      [3:0] DEPTH_NOW
);
  logic phase;

  // a slow core is ready only on every second cycle
  assign CORE_READY = !SLOW || phase;
  assign STACK_FULL = (DEPTH_NOW >= 4'(DEPTH));

  always_ff @(posedge CLK) begin
    if (RST) begin
      DEPTH_NOW <= 4'h0;
      phase     <= 1'b0;
    end else begin
      phase     <= !phase;
      // push on entry, pop on return
      DEPTH_NOW <= DEPTH_NOW + 4'(TAKE) - 4'(RET_IRQ);
    end
  end
endmodule

// [testbench/interrupt_source_logic_test.sv]
// Purpose: self-checking bench of the interrupt source logic
// Assumes: inputs change 1 ns after the rising clock edge
// Notes:   stack depth of one forces the full-stack stall
`timescale 1ns/1ps
module interrupt_source_logic_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic slow, adc_done, adc_en, adc_clr, lvd, ee, gie_set, gie_clr, return_from_irq_instr;
  logic [3:0] pin, ext_en, pin_sel, dir_in, pull_sel, ext_clr;
  logic [7:0] edge_sel;
  logic [1:0] cmp_out, cmp_en, cmp_clr;
  logic [13:0] tm_ev;
  logic [2:0] sim_ev;
  logic [17:0] uart_ev;
  logic [5:0] grp_en, grp_clr;
  isl_pkg::isl_src_t src_en, src_clr, src_f;
  logic gen, take, ready, full, wake, adc_f;
  isl_pkg::isl_vaddr_t vaddr;
  logic [3:0] ext_f, pull;
  logic [1:0] cmp_f;
  logic [5:0] grp_f;
  int failures, n_checks, cyc;

  isl_irq i_dut (.CLK(clk), .RST(rst), .EXT_PIN(pin), .EXT_EN(ext_en),
    .EXT_PIN_SEL(pin_sel), .EXT_DIR_IN(dir_in), .EXT_PULL_SEL(pull_sel),
    .EXT_EDGE(edge_sel), .EXT_CLR(ext_clr), .CMP_OUT(cmp_out),
    .CMP_EN(cmp_en), .CMP_CLR(cmp_clr), .ADC_DONE(adc_done),
    .ADC_EN(adc_en), .ADC_CLR(adc_clr), .TM_EV(tm_ev), .LVD_EV(lvd),
    .EE_EV(ee), .SIM_EV(sim_ev), .UART_EV(uart_ev), .SRC_EN(src_en),
    .SRC_CLR(src_clr), .GRP_EN(grp_en), .GRP_CLR(grp_clr),
    .GIE_SET(gie_set), .GIE_CLR(gie_clr), .RETURN_FROM_IRQ_INSTR(return_from_irq_instr),
    .STACK_FULL(full), .CORE_READY(ready), .GLOBAL_EN(gen), .TAKE(take),
    .VEC_ADDR(vaddr), .EXT_FLAG(ext_f), .CMP_FLAG(cmp_f), .ADC_FLAG(adc_f),
    .GRP_FLAG(grp_f), .SRC_FLAG(src_f), .PULL_EN(pull), .WAKE(wake));

  isl_core #(.DEPTH(1)) i_core (.CLK(clk), .RST(rst), .TAKE(take),
    .RET_IRQ(return_from_irq_instr), .SLOW(slow), .CORE_READY(ready), .STACK_FULL(full),
    .DEPTH_NOW());

  always #2.5 clk = ~clk;

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_take;
    for (int i = 0; i < 20 && take !== 1'b1; i++) step(1);
    chk(take, 1);
  endtask

  task automatic pulse_gie;
    gie_set = 1'b1;
    step(1);
    gie_set = 1'b0;
  endtask

  task automatic do_return_from_irq_instr;
    return_from_irq_instr = 1'b1;
    step(1);
    return_from_irq_instr = 1'b0;
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // hang guard
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {slow, adc_done, adc_en, adc_clr, lvd, ee, gie_set, gie_clr, return_from_irq_instr} = '0;
    {pin, ext_en, pin_sel, dir_in, pull_sel, ext_clr, edge_sel} = '0;
    {cmp_out, cmp_en, cmp_clr, tm_ev, sim_ev, uart_ev} = '0;
    {grp_en, grp_clr, src_en, src_clr} = '0;
    step(4);
    rst = 1'b0;
    step(3);
    chk(gen, 0);
    adc_done = 1'b1;
    step(1);
    adc_done = 1'b0;
    chk(adc_f, 1);
    chk(wake, 1);
    step(1);
    chk(wake, 0);
    {adc_done, adc_clr} = 2'h3;
    step(1);
    {adc_done, adc_clr} = 2'h0;
    chk(adc_f, 1);
    adc_en = 1'b1;
    pulse_gie();
    wait_take();
    chk(vaddr, 12'h01C);
    chk(gen, 0);
    chk(adc_f, 0);
    $display("test conversion done");
    // stack still full: pending requests must wait
    {adc_done, tm_ev[0], src_en[0], grp_en[0]} = 4'hF;
    step(1);
    {adc_done, tm_ev[0]} = 2'h0;
    pulse_gie();
    step(3);
    chk(take, 0);
    gie_clr = 1'b1;
    step(1);
    gie_clr = 1'b0;
    do_return_from_irq_instr();
    chk(gen, 1);
    wait_take();
    chk(vaddr, 12'h01C);
    chk(grp_f[0], 1);
    slow = 1'b1;
    do_return_from_irq_instr();
    wait_take();
    chk(vaddr, 12'h020);
    chk(grp_f[0], 0);
    chk(src_f[0], 1);
    do_return_from_irq_instr();
    src_clr = '1;
    step(1);
    src_clr = '0;
    chk(src_f, 0);
    $display("test priority and group done");
    for (int k = 0; k < 4; k++) begin
      {lvd, ee, sim_ev[1], uart_ev[5]} = 4'h8 >> k;
      step(1);
      {lvd, ee, sim_ev[1], uart_ev[5]} = 4'h0;
      chk(src_f, 20'h04000 << k);
      src_clr = '1;
      step(1);
      src_clr = '0;
    end
    chk(grp_f & 6'h28, 6'h28);
    grp_clr = 6'h28;
    step(1);
    grp_clr = 6'h00;
    chk(grp_f, 6'h00);
    $display("test source map done");
    gie_clr = 1'b1;
    step(1);
    gie_clr = 1'b0;
    {pull_sel, pin_sel, dir_in, ext_en} = 16'h5111;
    for (int c = 0; c < 4; c++) begin
      edge_sel = 8'(c);
      pin[0] = 1'b1;
      step(4);
      chk(ext_f[0], c[0]);
      ext_clr = 4'h1;
      step(1);
      ext_clr = 4'h0;
      pin[0] = 1'b0;
      step(4);
      chk(ext_f[0], c[1]);
      ext_clr = 4'h1;
      step(1);
      ext_clr = 4'h0;
    end
    chk(pull, 4'h5);
    edge_sel = 8'h01;
    dir_in = 4'h0;
    pin[0] = 1'b1;
    step(4);
    chk(ext_f[0], 0);
    dir_in = 4'h1;
    pin[0] = 1'b0;
    {cmp_out[1], cmp_en} = 3'h6;
    step(4);
    pin[0] = 1'b1;
    step(4);
    chk(cmp_f[1], 1);
    pulse_gie();
    wait_take();
    chk(vaddr, 12'h004);
    chk(ext_f, 0);
    do_return_from_irq_instr();
    wait_take();
    chk(vaddr, 12'h018);
    chk(cmp_f, 0);
    $display("test pins and comparators done");
    stop_test();
  end
endmodule
